// >>> core/lsf_limit_status_fault.sv
// Top: limit compare, live status, sticky faults and register port
// How it works
// R1: Power over bit is 1 while power exceeds its maximum threshold.
// R2: Power under bit is 1 while power is below its minimum threshold.
// R3: Sense over and under bits follow live comparison with thresholds.
// R4: Input-voltage over and under bits follow live comparison.
// R5: Auxiliary over bit is 1 while auxiliary exceeds its maximum.
// R6: Auxiliary under bit is 1 while auxiliary is below its minimum.
// R7: Live status reads at address 02h, power pair high, auxiliary low.
// R8: Power fault bits latch on a crossing and stay set until written 0.
// R9: Sense and input faults latch on crossings, zero only if none seen since reset or a write of 0.
// R10: Auxiliary fault bits latch when auxiliary crossed a threshold.
// R11: Fault register at 03h is read/write, same order as status.
// R12: Twelve-bit registers carry value bits 11..4 in their high byte.
// R13: Low byte holds bits 3..0 on top, lower nibble reads zero.
// R14: Twenty-four-bit power groups carry bits 23..16 in first byte.
// R15: Power groups carry bits 15..8 in the middle byte.
// R16: Power groups carry bits 7..0 in the last byte.
// R17: Host sets test mode before writing twelve-bit result registers.
// R18: Host sets test mode before writing power result registers.
// R19: Source select 1 computes power inside, 0 leaves it to host.
// R20: Alert raised only for crossings whose enable bit is 1.
// R21: Test mode halts converter updates and opens result writes.
// R22: Writing 0 clears a fault bit, writing 1 leaves it.
// R23: Status and faults update in the cycle the result is stored.
`timescale 1ns/10ps
module lsf_limit_status_fault
  import lsf_pkg::*;
(
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          arst_n,
  // Register port from the serial engine
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  // Converter results
  input  wire logic          meas_stb,
  input  wire lsf_meas_ch_t  meas_chan,
  input  wire logic [11:0]   meas_data,
  input  wire logic          power_stb,
  input  wire logic [23:0]   power_data,
  // Controls toward converter and alert pin logic
  output logic               test_write_enable,
  output logic               voltage_source_select,
  output logic               alert_request
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ctrl;
  logic [7:0] alert_enable;
  logic [7:0] live_limit_status;
  logic [7:0] sticky_limit_faults;

  lsf_chan_if #(.W(LSF_POWER_W)) pw_if ();
  lsf_chan_if #(.W(LSF_MEAS_W))  se_if ();
  lsf_chan_if #(.W(LSF_MEAS_W))  vi_if ();
  lsf_chan_if #(.W(LSF_MEAS_W))  ax_if ();

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire logic test_mode = ctrl[LSF_TEST_WRITE_ENABLE_BIT];
  wire logic vsrc      = ctrl[LSF_VOLTAGE_SOURCE_SELECT_BIT];
  wire logic ctrl_wr   = reg_wr && reg_addr == LSF_ADDR_CTRL;
  wire logic alert_wr  = reg_wr && reg_addr == LSF_ADDR_ALERT;
  wire logic fault_wr  = reg_wr && reg_addr == LSF_ADDR_FAULT;

  // Converter strobes per channel; power only when computed inside
  wire logic se_stb = meas_stb && meas_chan == LSF_CH_SENSE;
  wire logic vi_stb = meas_stb && meas_chan == LSF_CH_VIN;
  wire logic ax_stb = meas_stb && meas_chan == LSF_CH_AUX;
  wire logic pw_stb = power_stb && vsrc;                          // [R19]

  ////////////////////////////////////////////////////////////////////////
  // Channels: storage, byte layout and the test-mode write guard
  lsf_chan #(.W(LSF_POWER_W), .NB(LSF_POWER_NB), .BASE(LSF_POWER_BASE))
  u_power (                                             // [R14][R15][R16]
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .host_wr    (reg_wr),
    .host_addr  (reg_addr),
    .host_wdata (reg_wdata),
    .test_mode  (test_mode),                            // [R18][R21]
    .meas_stb   (pw_stb),
    .meas_data  (power_data),
    .ch         (pw_if)
  );

  lsf_chan #(.W(LSF_MEAS_W), .NB(LSF_MEAS_NB), .BASE(LSF_SENSE_BASE))
  u_sense (                                             // [R12][R13]
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .host_wr    (reg_wr),
    .host_addr  (reg_addr),
    .host_wdata (reg_wdata),
    .test_mode  (test_mode),                            // [R17][R21]
    .meas_stb   (se_stb),
    .meas_data  (meas_data),
    .ch         (se_if)
  );

  lsf_chan #(.W(LSF_MEAS_W), .NB(LSF_MEAS_NB), .BASE(LSF_VIN_BASE))
  u_vin (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .host_wr    (reg_wr),
    .host_addr  (reg_addr),
    .host_wdata (reg_wdata),
    .test_mode  (test_mode),
    .meas_stb   (vi_stb),
    .meas_data  (meas_data),
    .ch         (vi_if)
  );

  lsf_chan #(.W(LSF_MEAS_W), .NB(LSF_MEAS_NB), .BASE(LSF_AUX_BASE))
  u_aux (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .host_wr    (reg_wr),
    .host_addr  (reg_addr),
    .host_wdata (reg_wdata),
    .test_mode  (test_mode),
    .meas_stb   (ax_stb),
    .meas_data  (meas_data),
    .ch         (ax_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // Live status from the values the next edge stores
  wire logic [7:0] next_status = {
    pw_if.next_over, pw_if.next_under,                    // [R1][R2]
    se_if.next_over, se_if.next_under,                    // [R3]
    vi_if.next_over, vi_if.next_under,                    // [R4]
    ax_if.next_over, ax_if.next_under                     // [R5][R6]
  };

  // Faults set only when a new result lands, so threshold edits alone
  // do not record faults that no measurement ever showed
  wire logic [7:0] store_mask = {
    {2{pw_if.stored}}, {2{se_if.stored}},
    {2{vi_if.stored}}, {2{ax_if.stored}}
  };
  wire logic [7:0] fault_set  = store_mask & next_status;   // [R8][R9][R10]

  // Write of 0 clears, write of 1 keeps; a same-cycle set wins
  wire logic [7:0] fault_keep = fault_wr ?
                                (sticky_limit_faults & reg_wdata) :
                                sticky_limit_faults;        // [R22][R11]
  wire logic [7:0] next_fault = fault_keep | fault_set;

  wire logic [7:0] next_ctrl  = ctrl_wr ? (reg_wdata & LSF_CTRL_WMASK) :
                                ctrl;
  wire logic [7:0] next_alert = alert_wr ? reg_wdata : alert_enable;

  ////////////////////////////////////////////////////////////////////////
  // Read data selection; unmapped addresses read zero
  wire logic [7:0] rd_byte =
    (reg_addr == LSF_ADDR_CTRL)   ? ctrl                :
    (reg_addr == LSF_ADDR_ALERT)  ? alert_enable        :
    (reg_addr == LSF_ADDR_STATUS) ? live_limit_status   :   // [R7]
    (reg_addr == LSF_ADDR_FAULT)  ? sticky_limit_faults :   // [R11]
    pw_if.rd_hit ? pw_if.rd_byte :
    se_if.rd_hit ? se_if.rd_byte :
    vi_if.rd_hit ? vi_if.rd_byte :
    ax_if.rd_hit ? ax_if.rd_byte : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Control and alert enable registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl         <= LSF_CTRL_RST;
      alert_enable <= LSF_ALERT_RST;
    end else begin
      ctrl         <= next_ctrl;                              // [R21]
      alert_enable <= next_alert;
    end
  end

  // Status and faults move in the same edge as the result registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      live_limit_status   <= LSF_STATUS_RST;
      sticky_limit_faults <= LSF_FAULT_RST;
    end else begin
      live_limit_status   <= next_status;                     // [R23]
      sticky_limit_faults <= next_fault;                      // [R23]
    end
  end

  // Alert from recorded faults that are enabled
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      alert_request <= 1'b0;
    end else begin
      alert_request <= |(next_fault & next_alert);            // [R20]
    end
  end

  // Read data holds until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_byte;
    end
  end

  // Control outputs straight from the control flops
  assign test_write_enable     = ctrl[LSF_TEST_WRITE_ENABLE_BIT];
  assign voltage_source_select = ctrl[LSF_VOLTAGE_SOURCE_SELECT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  wire logic vi_lo_rd = reg_rd && reg_addr == LSF_VIN_BASE + 8'h01;
  wire logic vi_val_wr = reg_wr && reg_addr == LSF_VIN_BASE;

  pwr_over_live_a: assert property (                          // [R1]
    live_limit_status[LSF_POWER_OVER_BIT] ==
    (pw_if.value > pw_if.max_thr))
    else $error("power over status disagrees with compare");

  pwr_under_live_a: assert property (                         // [R2]
    live_limit_status[LSF_POWER_UNDER_BIT] ==
    (pw_if.value < pw_if.min_thr))
    else $error("power under status disagrees with compare");

  sense_live_a: assert property (                             // [R3]
    live_limit_status[LSF_SHUNT_OVER_BIT:LSF_SHUNT_UNDER_BIT] ==
    {se_if.value > se_if.max_thr, se_if.value < se_if.min_thr})
    else $error("sense status disagrees with compare");

  vin_live_a: assert property (                               // [R4]
    live_limit_status[LSF_INPUT_OVER_BIT:LSF_INPUT_UNDER_BIT] ==
    {vi_if.value > vi_if.max_thr, vi_if.value < vi_if.min_thr})
    else $error("input status disagrees with compare");

  aux_over_live_a: assert property (                          // [R5]
    live_limit_status[LSF_AUX_OVER_BIT] == (ax_if.value > ax_if.max_thr))
    else $error("aux over status disagrees with compare");

  aux_under_live_a: assert property (                         // [R6]
    live_limit_status[LSF_AUX_UNDER_BIT] == (ax_if.value < ax_if.min_thr))
    else $error("aux under status disagrees with compare");

  status_read_a: assert property (                            // [R7]
    reg_rd && reg_addr == LSF_ADDR_STATUS |=>
    reg_rdata == $past(live_limit_status))
    else $error("status read returned wrong byte");

  pwr_fault_hold_a: assert property (                         // [R8]
    sticky_limit_faults[LSF_POWER_OVER_BIT] &&
    !(fault_wr && !reg_wdata[LSF_POWER_OVER_BIT]) |=>
    sticky_limit_faults[LSF_POWER_OVER_BIT])
    else $error("power fault bit dropped without a clear");

  sense_fault_set_a: assert property (                        // [R9]
    se_if.stored && se_if.next_over |=>
    sticky_limit_faults[LSF_SHUNT_OVER_BIT])
    else $error("sense over fault not latched");

  aux_fault_set_a: assert property (                          // [R10]
    ax_if.stored && ax_if.next_under |=>
    sticky_limit_faults[LSF_AUX_UNDER_BIT])
    else $error("aux under fault not latched");

  fault_clear_a: assert property (                            // [R22]
    fault_wr && reg_wdata == 8'h00 && fault_set == 8'h00 |=>
    sticky_limit_faults == 8'h00)
    else $error("fault write of zero did not clear");

  low_nibble_a: assert property (                             // [R13]
    vi_lo_rd |=> reg_rdata[3:0] == 4'h0 &&
    reg_rdata[7:4] == $past(vi_if.value[3:0]))
    else $error("low byte layout wrong");

  result_guard_a: assert property (                           // [R17]
    !test_mode && vi_val_wr && !vi_stb |=> $stable(vi_if.value))
    else $error("result written outside test mode");

  halt_conv_a: assert property (                              // [R21]
    test_mode && !reg_wr |=> $stable(pw_if.value) && $stable(se_if.value))
    else $error("converter result taken in test mode");

  pwr_source_a: assert property (                             // [R19]
    !vsrc && !reg_wr |=> $stable(pw_if.value))
    else $error("power updated with external source selected");

  alert_gate_a: assert property (                             // [R20]
    alert_enable == 8'h00 && !alert_wr |=> !alert_request)
    else $error("alert raised with all enables off");

  fault_seen_c: cover property (
    $rose(sticky_limit_faults[LSF_POWER_OVER_BIT]));
  test_write_c: cover property (test_mode && vi_val_wr);
  alert_c: cover property ($rose(alert_request));
  clear_c: cover property (fault_wr && |sticky_limit_faults);

endmodule : lsf_limit_status_fault

// >>> core/lsf_pkg.sv
// Package: register map, field positions and reset values of the limit block
package lsf_pkg;

  // Byte addresses of the control, alert, status and fault registers
  localparam logic [7:0] LSF_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] LSF_ADDR_ALERT  = 8'h01;
  localparam logic [7:0] LSF_ADDR_STATUS = 8'h02;
  localparam logic [7:0] LSF_ADDR_FAULT  = 8'h03;

  // Base addresses of the channel groups (value, max, min, MSB first)
  localparam logic [7:0] LSF_POWER_BASE = 8'h04;
  localparam logic [7:0] LSF_SENSE_BASE = 8'h10;
  localparam logic [7:0] LSF_VIN_BASE   = 8'h18;
  localparam logic [7:0] LSF_AUX_BASE   = 8'h20;

  // Data widths and byte counts of the two register formats
  localparam int LSF_MEAS_W   = 12;
  localparam int LSF_MEAS_NB  = 2;
  localparam int LSF_POWER_W  = 24;
  localparam int LSF_POWER_NB = 3;

  // Control register fields and reset value
  localparam int         LSF_TEST_WRITE_ENABLE_BIT     = 4;
  localparam int         LSF_VOLTAGE_SOURCE_SELECT_BIT = 2;
  localparam logic [7:0] LSF_CTRL_RST                  = 8'h05;
  localparam logic [7:0] LSF_CTRL_WMASK                = 8'hF7;

  // Alert enable reset value
  localparam logic [7:0] LSF_ALERT_RST = 8'h00;

  // Status and fault bit positions, same order in both registers
  localparam int LSF_POWER_OVER_BIT  = 7;
  localparam int LSF_POWER_UNDER_BIT = 6;
  localparam int LSF_SHUNT_OVER_BIT  = 5;
  localparam int LSF_SHUNT_UNDER_BIT = 4;
  localparam int LSF_INPUT_OVER_BIT  = 3;
  localparam int LSF_INPUT_UNDER_BIT = 2;
  localparam int LSF_AUX_OVER_BIT    = 1;
  localparam int LSF_AUX_UNDER_BIT   = 0;
  localparam logic [7:0] LSF_STATUS_RST = 8'h00;
  localparam logic [7:0] LSF_FAULT_RST  = 8'h00;

  // Converter channel tags for 12-bit results
  typedef enum logic [1:0] {
    LSF_CH_SENSE,
    LSF_CH_VIN,
    LSF_CH_AUX
  } lsf_meas_ch_t;

endpackage : lsf_pkg

// >>> core/lsf_chan_if.sv
// Interface: one channel's values and live comparison toward the top
`timescale 1ns/10ps
interface lsf_chan_if #(
  parameter int W = 12
);
  logic [W-1:0] value;
  logic [W-1:0] max_thr;
  logic [W-1:0] min_thr;
  logic         next_over;
  logic         next_under;
  logic         stored;
  logic         rd_hit;
  logic [7:0]   rd_byte;

  modport chan (
    output value, max_thr, min_thr, next_over, next_under, stored,
    output rd_hit, rd_byte
  );
  modport top (
    input value, max_thr, min_thr, next_over, next_under, stored,
    input rd_hit, rd_byte
  );
endinterface : lsf_chan_if

// >>> core/lsf_byte_view.sv
// Byte view: left-justifies a value and picks one byte, MSB byte first
`timescale 1ns/10ps
module lsf_byte_view #(
  parameter int W  = 12,
  parameter int NB = 2
) (
  // Value and lane
  input  wire logic [W-1:0] value,
  input  wire logic [1:0]   lane,
  // Selected byte
  output logic      [7:0]   byte_out
);
  localparam int PW = NB * 8;

  // Unused low bits of the last byte read as zero
  wire logic [PW-1:0] just = PW'(value) << (PW - W);

  assign byte_out = just[(NB - 1 - int'(lane)) * 8 +: 8];
endmodule : lsf_byte_view

// >>> core/lsf_chan.sv
// Channel: result and thresholds with byte access and live comparison
`timescale 1ns/10ps
module lsf_chan
  import lsf_pkg::*;
#(
  parameter int         W    = 12,
  parameter int         NB   = 2,
  parameter logic [7:0] BASE = 8'h10
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  // Host byte port
  input  wire logic         host_wr,
  input  wire logic [7:0]   host_addr,
  input  wire logic [7:0]   host_wdata,
  // Converter side
  input  wire logic         test_mode,
  input  wire logic         meas_stb,
  input  wire logic [W-1:0] meas_data,
  // Toward the top
  lsf_chan_if.chan          ch
);
  localparam int         PW   = NB * 8;
  localparam logic [7:0] SPAN = 8'(3 * NB);
  localparam logic [7:0] NB8  = 8'(NB);

  // Field 0 is the result, 1 the maximum, 2 the minimum threshold
  logic [W-1:0] fld      [3];
  logic [W-1:0] next_fld [3];
  logic [7:0]   view     [3];

  function automatic logic [W-1:0] put_byte(input logic [W-1:0] v,
                                            input logic [1:0]   ln,
                                            input logic [7:0]   d);
    logic [PW-1:0] p;
    p = PW'(v) << (PW - W);
    p[(NB - 1 - int'(ln)) * 8 +: 8] = d;
    return p[PW-1 -: W];
  endfunction : put_byte

  // Address decode, shared by writes and reads
  wire logic [7:0] rel     = host_addr - BASE;
  wire logic       in_rng  = rel < SPAN;
  wire logic [1:0] fld_sel = 2'(rel / NB8);
  wire logic [1:0] lane    = 2'(rel % NB8);
  wire logic       wr_hit  = host_wr && in_rng;
  // Result bytes accept host data only in test mode
  wire logic       wr_ok   = wr_hit && (fld_sel != 2'h0 || test_mode);
  // Converter results are ignored while test mode halts it
  wire logic       take    = meas_stb && !test_mode;

  // Next values: converter result or host byte merge
  always_comb begin
    next_fld = fld;
    if (take) begin
      next_fld[0] = meas_data;
    end
    if (wr_ok) begin
      next_fld[fld_sel] = put_byte(fld[fld_sel], lane, host_wdata);
    end
  end

  // Maximum resets open so no limit trips before software sets it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fld[0] <= '0;
      fld[1] <= '1;
      fld[2] <= '0;
    end else begin
      fld <= next_fld;
    end
  end

  // Byte views of the three fields for reads
  for (genvar f = 0; f < 3; f++) begin : g_view
    lsf_byte_view #(.W(W), .NB(NB)) u_view (
      .value    (fld[f]),
      .lane     (lane),
      .byte_out (view[f])
    );
  end

  // Comparisons on the values that the next edge stores
  assign ch.value      = fld[0];
  assign ch.max_thr    = fld[1];
  assign ch.min_thr    = fld[2];
  assign ch.next_over  = next_fld[0] > next_fld[1];
  assign ch.next_under = next_fld[0] < next_fld[2];
  assign ch.stored     = take || (wr_ok && fld_sel == 2'h0);
  assign ch.rd_hit     = in_rng;
  assign ch.rd_byte    = (fld_sel == 2'h2) ? view[2] :
                         (fld_sel == 2'h1) ? view[1] : view[0];
endmodule : lsf_chan

// >>> dv/lsf_host_model.sv
// Host register-port model: byte writes and reads on the register port
`timescale 1ns/10ps
module lsf_host_model
  import lsf_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Idle port at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // One-cycle write; released lines show the inverse so stale data is seen
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : write
  // One-cycle read; data is registered at the strobe edge and then held
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask : read
  // Result bytes only take a write while test mode is set
  task automatic test_write(input logic [7:0] a, input logic [7:0] d);
    write(LSF_ADDR_CTRL, LSF_CTRL_RST | 8'h10);
    write(a, d);
    write(LSF_ADDR_CTRL, LSF_CTRL_RST);
  endtask : test_write
endmodule : lsf_host_model

// >>> dv/lsf_limit_status_fault_tb.sv
// Self-checking bench of the limit, status and fault register block
`timescale 1ns/10ps
`define CHK(g, e) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); \
  end \
end
module lsf_limit_status_fault_tb
  import lsf_pkg::*;
;
  logic         core_clk;
  logic         arst_n;
  logic [7:0]   reg_addr;
  logic         reg_wr;
  logic [7:0]   reg_wdata;
  logic         reg_rd;
  logic [7:0]   reg_rdata;
  logic         meas_stb;
  lsf_meas_ch_t meas_chan;
  logic [11:0]  meas_data;
  logic         power_stb;
  logic [23:0]  power_data;
  logic         test_write_enable;
  logic         voltage_source_select;
  logic         alert_request;
  logic [23:0]  val [4];
  logic [23:0]  mx [4];
  logic [23:0]  mn [4];
  logic [23:0]  lv;
  logic [7:0]   flt;
  logic [7:0]   en;
  logic [7:0]   lw;
  logic [15:0]  seed;
  logic         src;
  logic         tm;
  int           lc;
  int           fail_count = 0;
  int           total_checks = 0;
  int           cycles = 0;

  lsf_limit_status_fault lsf_limit_status_fault_i (.*);
  lsf_host_model lsf_host_model_i (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // Clock and hang guard
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Expectation helpers: index 0 sense, 1 input, 2 aux, 3 power
  function automatic int obit(int c);
    return (c == 3) ? 7 : 5 - 2 * c;
  endfunction : obit
  function automatic int nb(int c);
    return (c == 3) ? 3 : 2;
  endfunction : nb
  function automatic logic [7:0] base(int c);
    return (c == 3) ? LSF_POWER_BASE : (c == 0) ? LSF_SENSE_BASE :
           (c == 1) ? LSF_VIN_BASE : LSF_AUX_BASE;
  endfunction : base
  function automatic logic [23:0] wmask(int c);
    return (c == 3) ? 24'hFFFFFF : 24'h000FFF;
  endfunction : wmask
  // Left-justified byte k, most significant first; low nibble of 12 is 0
  function automatic logic [7:0] byte_of(logic [23:0] v, int c, int k);
    logic [23:0] lj;
    lj = (c == 3) ? v : v << 4;
    return 8'(lj >> (8 * (nb(c) - 1 - k)));
  endfunction : byte_of
  function automatic logic [7:0] live();
    logic [7:0] s;
    s = 8'h00;
    for (int c = 0; c < 4; c++) begin
      s[obit(c)] = val[c] > mx[c];
      s[obit(c) - 1] = val[c] < mn[c];
    end
    return s;
  endfunction : live
  function logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  ////////////////////////////////////////////////////////////////////////
  // Bus and converter tasks
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    lsf_host_model_i.read(a, r);
    `CHK(r, e)
  endtask : rd_chk
  task automatic store(int c, logic [23:0] v);
    @(negedge core_clk);
    if (c == 3) begin
      power_stb  = 1'b1;
      power_data = v;
    end else begin
      meas_stb  = 1'b1;
      meas_chan = lsf_meas_ch_t'(c);
      meas_data = v[11:0];
    end
    @(negedge core_clk);
    meas_stb   = 1'b0;
    power_stb  = 1'b0;
    meas_data  = ~meas_data;
    power_data = ~power_data;
    if (!tm && (c != 3 || src)) begin
      val[c] = v;
      flt = flt | (live() & (8'h03 << (obit(c) - 1)));
    end
  endtask : store
  task automatic set_thr(int c, logic [23:0] a, logic [23:0] b);
    mx[c] = a & wmask(c);
    mn[c] = b & wmask(c);
    for (int k = 0; k < nb(c); k++) begin
      lsf_host_model_i.write(8'(base(c) + nb(c) + k), byte_of(a, c, k));
      lsf_host_model_i.write(8'(base(c) + 2 * nb(c) + k), byte_of(b, c, k));
    end
    for (int k = 0; k < nb(c); k++) begin
      rd_chk(8'(base(c) + nb(c) + k), byte_of(mx[c], c, k));
      rd_chk(8'(base(c) + 2 * nb(c) + k), byte_of(mn[c], c, k));
    end
  endtask : set_thr
  task automatic chk_all(int c);
    rd_chk(LSF_ADDR_STATUS, live());
    rd_chk(LSF_ADDR_FAULT, flt);
    for (int k = 0; k < nb(c); k++) begin
      rd_chk(8'(base(c) + k), byte_of(val[c], c, k));
    end
    `CHK(alert_request, |(flt & en))
  endtask : chk_all
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    core_clk   = 1'b0;
    arst_n     = 1'b0;
    meas_stb   = 1'b0;
    meas_chan  = LSF_CH_SENSE;
    meas_data  = 12'h000;
    power_stb  = 1'b0;
    power_data = 24'h000000;
    seed       = 16'h004A;
    flt        = 8'h00;
    en         = 8'h00;
    src        = 1'b1;
    tm         = 1'b0;
    for (int c = 0; c < 4; c++) begin
      val[c] = 24'h000000;
      mx[c]  = wmask(c);
      mn[c]  = 24'h000000;
    end
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    rd_chk(LSF_ADDR_CTRL, LSF_CTRL_RST);
    rd_chk(LSF_ADDR_ALERT, LSF_ALERT_RST);
    rd_chk(LSF_ADDR_FAULT, LSF_FAULT_RST);
    `CHK(voltage_source_select, 1'b1)
    `CHK(test_write_enable, 1'b0)
    lsf_host_model_i.write(LSF_ADDR_STATUS, 8'hFF);
    rd_chk(LSF_ADDR_STATUS, LSF_STATUS_RST);
    rd_chk(8'h3F, 8'h00);
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      set_thr(c, 24'({rnd(), rnd()}), 24'(rnd() >> 6));
    end
    $display("test thresholds done");
    // Random results with boundary picks around both thresholds
    for (int i = 0; i < 48; i++) begin
      lc = rnd() % 4;
      lv = 24'({rnd(), rnd()}) & wmask(lc);
      case (rnd() % 4)
        0: lv = (mx[lc] + 24'h1) & wmask(lc);
        1: lv = mx[lc];
        2: lv = (mn[lc] - 24'h1) & wmask(lc);
        default: ;
      endcase
      store(lc, lv);
      chk_all(lc);
      if (i % 6 == 5) begin
        lw = 8'(rnd());
        lsf_host_model_i.write(LSF_ADDR_FAULT, lw);
        flt = flt & lw;
        rd_chk(LSF_ADDR_FAULT, flt);
        en = lw ^ 8'h5A;
        lsf_host_model_i.write(LSF_ADDR_ALERT, en);
      end
    end
    $display("test random done");
    // Power result dropped while the host does the multiply
    lsf_host_model_i.write(LSF_ADDR_CTRL, 8'h01);
    src = 1'b0;
    `CHK(voltage_source_select, 1'b0)
    store(3, val[3] ^ 24'h123456);
    chk_all(3);
    lsf_host_model_i.write(LSF_ADDR_CTRL, LSF_CTRL_RST);
    src = 1'b1;
    $display("test source done");
    // Test mode: control bit 3 is read-only, converter results dropped
    lsf_host_model_i.write(LSF_ADDR_CTRL, 8'h1D);
    tm = 1'b1;
    rd_chk(LSF_ADDR_CTRL, 8'h15);
    `CHK(test_write_enable, 1'b1)
    store(2, ~val[2] & 24'h000FFF);
    chk_all(2);
    lsf_host_model_i.write(LSF_ADDR_CTRL, LSF_CTRL_RST);
    tm = 1'b0;
    lsf_host_model_i.write(LSF_VIN_BASE, ~byte_of(val[1], 1, 0));
    chk_all(1);
    lv = 24'({rnd(), rnd()});
    lsf_host_model_i.test_write(LSF_VIN_BASE, lv[7:0]);
    val[1][11:4] = lv[7:0];
    flt = flt | (live() & 8'h0C);
    lsf_host_model_i.test_write(LSF_POWER_BASE + 8'h02, lv[15:8]);
    val[3][7:0] = lv[15:8];
    flt = flt | (live() & 8'hC0);
    chk_all(1);
    chk_all(3);
    $display("test mode done");
    print_verdict();
  end
endmodule : lsf_limit_status_fault_tb
